// >>> hw/pcs_consts.svh
/*
 * Register offsets, field positions and reset values of the pad control
 * block. Assumes inclusion by bare name from any design or bench file.
 */
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PCS_ADDR_PAD_DIRECTION_ENABLE 7'h44
`define PCS_ADDR_PAD_OUTPUT_VALUE     7'h45
`define PCS_ADDR_PAD_INPUT_LEVEL      7'h46
`define PCS_ADDR_SIGNAL_OUTPUT_SELECT 7'h47
`define PCS_ADDR_SILICON_REVISION     7'h7F

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCS_PIN_SIGNAL_INPUT   7
`define PCS_PIN_CLOCK_OUTPUT   6
`define PCS_PIN_INTERFACE_SEL_1 5
`define PCS_PIN_INTERFACE_SEL_0 4
`define PCS_SCAN_PIN_TOP       3
`define PCS_FAST_SPEED_BIT     7
`define PCS_SOURCE_TOP         3

// ----------------------------------------------------------------------
// Reset values, scan pin mask and unmapped read value
// ----------------------------------------------------------------------
`define PCS_RST_DIRECTION      8'h00
`define PCS_RST_OUTPUT_VALUE   8'h00
`define PCS_RST_SOURCE         4'h0
`define PCS_RST_FAST           1'b0
`define PCS_SCAN_PIN_MASK      8'h0F
`define PCS_READ_UNMAPPED      8'h00

`endif

// >>> hw/pcs_pkg.sv
/*
 * Types of the pad control block.
 * Assumes the constants header is available to the includer.
 */
package pcs_pkg;

    // ------------------------------------------------------------------
    // Signal output source codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PCS_SRC_TRISTATE_0 = 4'h0,
        PCS_SRC_TRISTATE_1 = 4'h1,
        PCS_SRC_DRIVE_LOW  = 4'h2,
        PCS_SRC_DRIVE_HIGH = 4'h3,
        PCS_SRC_TX_ENV     = 4'h4,
        PCS_SRC_TX_ACTIVE  = 4'h5,
        PCS_SRC_SECURE     = 4'h6,
        PCS_SRC_RX_ENV     = 4'h7,
        PCS_SRC_RX_ACTIVE  = 4'h8,
        PCS_SRC_RX_BIT     = 4'h9
    } pcs_source_t;

    // ------------------------------------------------------------------
    // Internal observation signals for the signal output pin
    // ------------------------------------------------------------------
    typedef struct packed {
        logic tx_envelope;
        logic tx_active;
        logic secure_module_serial_signal;
        logic rx_envelope;
        logic rx_active;
        logic rx_bit;
    } pcs_obs_t;

    // ------------------------------------------------------------------
    // Register access request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } pcs_req_t;

endpackage

// >>> hw/pcs_signal_output_pin_mux.sv
/*
 * Selector for the dedicated signal output pin.
 * Assumes a registered code and synchronous observation signals.
 */
`include "pcs_consts.svh"

module pcs_signal_output_mux
    import pcs_pkg::*;
(
    // Selection
    input  wire logic [3:0] i_code,
    input  wire pcs_obs_t   i_obs,
    // Pin drive
    output logic            o_level,
    output logic            o_oe
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    always_comb begin
        o_level = 1'b0;
        o_oe    = 1'b1;
        // Reserved codes float the pin so nothing undefined reaches the board.
        unique case (i_code)
            PCS_SRC_TRISTATE_0,
            PCS_SRC_TRISTATE_1: o_oe = 1'b0;
            PCS_SRC_DRIVE_LOW:  o_level = 1'b0;
            PCS_SRC_DRIVE_HIGH: o_level = 1'b1;
            PCS_SRC_TX_ENV:     o_level = i_obs.tx_envelope;
            PCS_SRC_TX_ACTIVE:  o_level = i_obs.tx_active;
            PCS_SRC_SECURE: begin
                o_level = i_obs.secure_module_serial_signal;
            end
            PCS_SRC_RX_ENV:     o_level = i_obs.rx_envelope;
            PCS_SRC_RX_ACTIVE:  o_level = i_obs.rx_active;
            PCS_SRC_RX_BIT:     o_level = i_obs.rx_bit;
            default:            o_oe = 1'b0;
        endcase
    end

endmodule

// >>> hw/pcs_pad_ctrl.sv
/*
 * Pad configuration and signal output block: direction, output value,
 * input level, signal output select and silicon revision registers.
 * Assumes a single-cycle register port from the host interface and pin
 * inputs synchronous to i_clk. The pad buffers, the scan port and the
 * radio observation signals live outside; this block only decides who
 * drives each pin and with what level. The scan enable comes from the
 * nonvolatile configuration and is taken as a steady level.
 */
`include "pcs_consts.svh"

module pcs_pad_ctrl
    import pcs_pkg::*;
#(
    // Arbitrary neutral revision codes.
    parameter logic [3:0] VERSION_CODE    = 4'h3,
    parameter logic [3:0] SUBVERSION_CODE = 4'h5
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    // Register port
    input  wire pcs_req_t   i_req,
    output logic [7:0]      o_rdata,
    output logic            o_rvalid,
    // Configuration
    input  wire logic       i_boundary_scan_en,
    // Pins
    input  wire logic [7:0] i_pad_in,
    output logic [7:0]      o_pad_out,
    output logic [7:0]      o_pad_oe,
    output logic            o_clock_output_function_en,
    output logic            o_fast_pad_switching,
    // Signal output pin
    input  wire pcs_obs_t   i_obs,
    output logic            o_signal_output_pin,
    output logic            o_signal_output_pin_oe
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Software-visible state. Only bits that hold a setting are stored;
    // spare and read-only bits are rebuilt on the read path. A write
    // lands at the edge that takes it, and the pins follow one edge
    // later through the output stage below.
    logic [7:0] pad_direction_enable_r;
    logic [7:0] pad_output_value_r;
    logic [3:0] signal_output_source_r;
    logic       fast_pad_switching_r;
    logic       mux_level;
    logic       mux_oe;
    logic [7:0] oe_nxt;
    logic [7:0] rdata_nxt;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pad_direction_enable_r <= `PCS_RST_DIRECTION;
        end else if (i_req.wr &&
                     i_req.addr == `PCS_ADDR_PAD_DIRECTION_ENABLE) begin
            pad_direction_enable_r <= i_req.wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pad_output_value_r <= `PCS_RST_OUTPUT_VALUE;
        end else if (i_req.wr &&
                     i_req.addr == `PCS_ADDR_PAD_OUTPUT_VALUE) begin
            pad_output_value_r <= i_req.wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            signal_output_source_r <= `PCS_RST_SOURCE;
            fast_pad_switching_r   <= `PCS_RST_FAST;
        end else if (i_req.wr &&
                     i_req.addr == `PCS_ADDR_SIGNAL_OUTPUT_SELECT) begin
            signal_output_source_r <= i_req.wdata[`PCS_SOURCE_TOP:0];
            fast_pad_switching_r   <= i_req.wdata[`PCS_FAST_SPEED_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------------
    // All three pin registers share one bit order: bit 7 is the signal
    // input pin, bit 6 the clock output pin, bits 5 and 4 the interface
    // select pins and bits 3 to 0 the four scan pins.
    // Scan pins stay with the scan logic while scan is on, so their
    // direction bits are masked rather than cleared in the register.
    // Software then finds its own setting again once scan is off, with
    // no need to rewrite the direction register.
    localparam logic [7:0] SCAN_PINS = `PCS_SCAN_PIN_MASK;

    for (genvar p = 0; p < 8; p++) begin : g_pad_dir
        logic scan_owned;
        // Only the pins of the scan port can be taken by the scan logic.
        assign scan_owned = i_boundary_scan_en && SCAN_PINS[p];
        assign oe_nxt[p]  = pad_direction_enable_r[p] &&
                            !scan_owned;
    end

    // Each pin control is a flop of its own so the board sees no decode
    // glitch; the price is one clock of lag behind the registers.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pad_oe <= 8'h00;
        end else begin
            o_pad_oe <= oe_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pad_out <= 8'h00;
        end else begin
            o_pad_out <= pad_output_value_r;
        end
    end

    // The clock function follows the direction bit of its pin: it is
    // on at reset and whenever software leaves that pin an input.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_clock_output_function_en <= 1'b1;
        end else begin
            o_clock_output_function_en <=
                ~pad_direction_enable_r[`PCS_PIN_CLOCK_OUTPUT];
        end
    end

    // Fast switching raises peak supply current when many pins toggle.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_fast_pad_switching <= 1'b0;
        end else begin
            o_fast_pad_switching <= fast_pad_switching_r;
        end
    end

    // ------------------------------------------------------------------
    // Signal output pin
    // ------------------------------------------------------------------
    // The code table sits in a module of its own so that it can be read
    // and checked apart from the register logic.
    pcs_signal_output_mux u_signal_output_mux (
        .i_code  (signal_output_source_r),
        .i_obs   (i_obs),
        .o_level (mux_level),
        .o_oe    (mux_oe)
    );

    // One register stage keeps the pin glitch-free across code changes.
    // Observation levels therefore reach the pin one clock after a change.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_signal_output_pin    <= 1'b0;
            o_signal_output_pin_oe <= 1'b0;
        end else begin
            o_signal_output_pin    <= mux_level;
            o_signal_output_pin_oe <= mux_oe;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // The read-only registers have no storage here; writes to their
    // offsets match no write decode above and so change nothing. Spare
    // bits 6 to 4 of the select register read back as zero.
    always_comb begin
        rdata_nxt = `PCS_READ_UNMAPPED;
        unique case (i_req.addr)
            `PCS_ADDR_PAD_DIRECTION_ENABLE:
                rdata_nxt = pad_direction_enable_r;
            `PCS_ADDR_PAD_OUTPUT_VALUE:
                rdata_nxt = pad_output_value_r;
            `PCS_ADDR_PAD_INPUT_LEVEL:
                rdata_nxt = i_pad_in;
            `PCS_ADDR_SIGNAL_OUTPUT_SELECT:
                rdata_nxt = {fast_pad_switching_r, 3'h0,
                             signal_output_source_r};
            `PCS_ADDR_SILICON_REVISION:
                rdata_nxt = {VERSION_CODE, SUBVERSION_CODE};
            default:
                rdata_nxt = `PCS_READ_UNMAPPED;
        endcase
    end

    // The read strobe is echoed one clock later as the data qualifier.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
        end
    end

    // Read data holds between reads, so a slow host may sample it late.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else if (i_req.rd) begin
            o_rdata <= rdata_nxt;
        end
    end

endmodule

// >>> tb/pcs_pad_ctrl_sva.sv
/* Checker for the pad control block.
   Sees only the top ports; bound to the design from the bench. */
module pcs_pad_ctrl_sva
    import pcs_pkg::*;
#(
    parameter logic [3:0] VERSION_CODE    = 4'h3,
    parameter logic [3:0] SUBVERSION_CODE = 4'h5
) (
    // Clock, reset and register port
    input wire logic       i_clk,
    input wire logic       i_arst_n,
    input wire pcs_req_t   i_req,
    input wire logic [7:0] o_rdata,
    input wire logic       o_rvalid,
    // Pins
    input wire logic       i_boundary_scan_en,
    input wire logic [7:0] i_pad_in,
    input wire logic [7:0] o_pad_out,
    input wire logic [7:0] o_pad_oe,
    input wire logic       o_clock_output_function_en,
    input wire logic       o_fast_pad_switching,
    input wire pcs_obs_t   i_obs,
    input wire logic       o_signal_output_pin,
    input wire logic       o_signal_output_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic wr_dir = i_req.wr && i_req.addr == 7'h44;
    wire logic wr_out = i_req.wr && i_req.addr == 7'h45;
    wire logic wr_sel = i_req.wr && i_req.addr == 7'h47;
    wire logic rd_in  = i_req.rd && i_req.addr == 7'h46;
    wire logic rd_ver = i_req.rd && i_req.addr == 7'h7F;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    dir_to_oe_a: assert property (wr_dir |-> ##2
        o_pad_oe[7:4] == $past(i_req.wdata[7:4], 2)) else $error("oe bad");
    scan_mask_a: assert property ($past(i_boundary_scan_en) |->
        o_pad_oe[3:0] == 4'h0) else $error("scan mask bad");
    clk_func_a: assert property (
        o_clock_output_function_en == !o_pad_oe[6])
        else $error("clk fn bad");
    out_value_a: assert property (wr_out |-> ##2
        o_pad_out == $past(i_req.wdata, 2)) else $error("pad out bad");
    pad_read_a: assert property (rd_in |=> o_rvalid &&
        o_rdata == $past(i_pad_in)) else $error("pad read bad");
    rev_read_a: assert property (rd_ver |=>
        o_rdata == {VERSION_CODE, SUBVERSION_CODE}) else $error("rev bad");
    pad_speed_a: assert property (wr_sel |-> ##2
        o_fast_pad_switching == $past(i_req.wdata[7], 2)) else $error("spd");
    fixed_level_a: assert property (wr_sel && i_req.wdata[3:1] == 3'h1
        |-> ##2 o_signal_output_pin_oe &&
        o_signal_output_pin == $past(i_req.wdata[0], 2)) else $error("lvl");
    float_out_a: assert property (wr_sel && i_req.wdata[3:1] == 3'h0
        |-> ##2 !o_signal_output_pin_oe) else $error("float bad");
    rsvd_float_a: assert property (wr_sel && i_req.wdata[3:0] > 4'h9
        |-> ##2 !o_signal_output_pin_oe) else $error("rsvd bad");

    cover property (wr_sel ##2 o_signal_output_pin_oe);
    cover property (rd_ver ##1 o_rvalid);
    cover property ($past(i_boundary_scan_en) && o_pad_oe[7]);
endmodule

// >>> tb/pcs_board_model.sv
/* Board around the configurable pins.
   Assumes the device enables are active high. */
module pcs_board_model (
    // Device drive
    input  wire logic [7:0] i_pad_out,
    input  wire logic [7:0] i_pad_oe,
    // Board levels and pin levels
    input  wire logic [7:0] i_board_level,
    output logic [7:0]      o_pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // An undriven pin shows the board level, never a stale device value.
    assign o_pad_in = (i_pad_oe & i_pad_out)
                    | (~i_pad_oe & i_board_level);
endmodule

// >>> tb/testbench.sv
/* Self-checking bench for the pad control block.
   Assumes the single-cycle register port described for the design. */
module testbench
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Arbitrary revision codes, distinct from the design defaults.
    localparam logic [3:0] VER = 4'h6;
    localparam logic [3:0] SUB = 4'h2;
    logic       i_clk, i_arst_n, i_boundary_scan_en, o_rvalid, o_clk_fn;
    logic       o_fast, o_sig, o_sig_oe;
    logic [7:0] o_rdata, o_pad_out, o_pad_oe, pad_in, board;
    logic [7:0] sig_seen;
    pcs_req_t   i_req;
    pcs_obs_t   i_obs;
    int         miscompares, checks_done, cycles;

    pcs_pad_ctrl #(.VERSION_CODE(VER), .SUBVERSION_CODE(SUB)) uut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(i_req),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .i_boundary_scan_en(i_boundary_scan_en), .i_pad_in(pad_in),
        .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
        .o_clock_output_function_en(o_clk_fn),
        .o_fast_pad_switching(o_fast), .i_obs(i_obs),
        .o_signal_output_pin(o_sig), .o_signal_output_pin_oe(o_sig_oe));
    pcs_board_model board_i (.i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
        .i_board_level(board), .o_pad_in(pad_in));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic chk(input string n, input logic [7:0] s,
                       input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // Write: taken at the next edge, pins settle one edge later.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_clk);
        i_req = '0;
        repeat (2) @(negedge i_clk);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e,
                      input string n);
        @(negedge i_clk);
        i_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge i_clk);
        i_req = '0;
        chk(n, {7'h00, o_rvalid}, 8'h01);
        chk(n, o_rdata, e);
    endtask

    function automatic logic [7:0] sig_exp(input int c, input int k);
        if (c < 2 || c > 9) return 8'h00;
        if (c < 4) return {6'h00, 1'b1, c == 3};
        return {6'h00, 1'b1, 9 - c == k};
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        i_arst_n = 1'b0;
        i_req = '0;
        i_obs = '0;
        i_boundary_scan_en = 1'b0;
        board = 8'h3C;
        repeat (8) @(negedge i_clk);
        i_arst_n = 1'b1;
        chk("oe", o_pad_oe, 8'h00);
        chk("clk fn", {7'h00, o_clk_fn}, 8'h01);
        chk("sig rst", {6'h00, o_sig_oe, o_sig}, 8'h00);
        chk("fast rst", {7'h00, o_fast}, 8'h00);
        rd(7'h44, 8'h00, "dir");
        rd(7'h45, 8'h00, "out");
        rd(7'h47, 8'h00, "sel");
        rd(7'h7F, {VER, SUB}, "rev");
        rd(7'h10, 8'h00, "unmapped");
        rd(7'h46, 8'h3C, "in idle");
        $display("test reset done");
        wr(7'h44, 8'hFF);
        wr(7'h45, 8'hA5);
        chk("oe", o_pad_oe, 8'hFF);
        chk("out", o_pad_out, 8'hA5);
        chk("clk fn", {7'h00, o_clk_fn}, 8'h00);
        wr(7'h46, 8'h00);
        wr(7'h7F, 8'h00);
        rd(7'h46, 8'hA5, "in driven");
        rd(7'h7F, {VER, SUB}, "rev ro");
        i_boundary_scan_en = 1'b1;
        repeat (2) @(negedge i_clk);
        chk("oe scan", o_pad_oe, 8'hF0);
        rd(7'h46, 8'hAC, "in scan");
        i_boundary_scan_en = 1'b0;
        wr(7'h44, 8'h00);
        chk("oe off", o_pad_oe, 8'h00);
        chk("clk fn", {7'h00, o_clk_fn}, 8'h01);
        $display("test pins done");
        wr(7'h47, 8'hFF);
        rd(7'h47, 8'h8F, "sel rfu");
        chk("fast", {7'h00, o_fast}, 8'h01);
        for (int c = 0; c < 16; c++) begin
            for (int k = 0; k < 6; k++) begin
                i_obs = pcs_obs_t'(6'h01 << k);
                wr(7'h47, 8'(c));
                sig_seen = {6'h00, o_sig_oe, o_sig & o_sig_oe};
                chk("sig", sig_seen, sig_exp(c, k));
            end
        end
        chk("fast", {7'h00, o_fast}, 8'h00);
        $display("test signal output done");
        close_out();
    end
endmodule

bind pcs_pad_ctrl pcs_pad_ctrl_sva #(.VERSION_CODE(VERSION_CODE),
    .SUBVERSION_CODE(SUBVERSION_CODE)) u_sva (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_boundary_scan_en(i_boundary_scan_en),
    .i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
    .o_clock_output_function_en(o_clock_output_function_en),
    .o_fast_pad_switching(o_fast_pad_switching), .i_obs(i_obs),
    .o_signal_output_pin(o_signal_output_pin),
    .o_signal_output_pin_oe(o_signal_output_pin_oe));
